/* File: shared/dcs_pkg.sv */
package dcs_pkg;
    localparam logic [15:0] OFS_LAST_ALARM = 16'h603F;
    localparam logic [15:0] OFS_CMD_WORD = 16'h6040;
    localparam logic [15:0] OFS_STATE_WORD = 16'h6041;
    localparam logic [15:0] RST_LAST_ALARM = 16'h0000;
    localparam logic [15:0] RST_CMD_WORD = 16'h0000;
    localparam int CB_SWITCH_ON = 0;
    localparam int CB_ENABLE_VOLT = 1;
    localparam int CB_QUICK_STOP = 2;
    localparam int CB_ENABLE_OP = 3;
    localparam int CB_NEW_SETPOINT = 4;
    localparam int CB_IMMEDIATE = 5;
    localparam int CB_RELATIVE = 6;
    localparam int CB_FAULT_RESET = 7;
    localparam int CB_HALT = 8;
    localparam int CB_CHANGE_ON_SP = 9;
    localparam int SB_VOLTAGE = 4;
    localparam int SB_QUICK_STOP = 5;
    localparam int SB_SW_ON_DIS = 6;
    localparam int SB_WARNING = 7;
    localparam int SB_REMOTE = 9;
    localparam int SB_TARGET = 10;
    localparam int SB_LIMIT = 11;
    localparam int SB_ATTAINED = 12;
    localparam int SB_HOME_ERR = 13;
    localparam int SB_ABS_VALID = 14;
    // Final reaction count; a fault reaction is shown this many cycles plus one before entering the fault state.
    localparam logic [7:0] FAULT_REACT_CYCLES = 8'h04;

    typedef enum logic [3:0] {
        ST_NOT_READY = 4'b0000,
        ST_SW_ON_DIS = 4'b0001,
        ST_READY = 4'b0010,
        ST_SWITCHED_ON = 4'b0011,
        ST_OP_ENABLED = 4'b0100,
        ST_QSTOP = 4'b0101,
        ST_FAULT_REACT = 4'b0110,
        ST_FAULT = 4'b0111
    } dcs_state_t;

    typedef enum logic [1:0] {
        MODE_PROFILE_POSITION = 2'b00,
        MODE_PROFILE_VELOCITY = 2'b01,
        MODE_PROFILE_TORQUE = 2'b10,
        MODE_HOMING_MODE = 2'b11
    } dcs_mode_t;

    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_SHUTDOWN = 2'b01,
        CMD_SWITCH_ON = 2'b10,
        CMD_ENABLE_OP = 2'b11
    } dcs_cmd_t;
endpackage

/* File: rtl/dcs_cmd_decode.sv */
`timescale 1ns/100ps
module dcs_cmd_decode
    import dcs_pkg::*;
(
    // Raw control bits.
    input wire logic [3:0] cmdBits,
    // Decoded commands.
    output logic disableVolt,
    output logic quickStop,
    output dcs_cmd_t cmd
);
    always_comb begin
        disableVolt = 1'b0;
        quickStop = 1'b0;
        cmd = CMD_NONE;
        if (!cmdBits[CB_ENABLE_VOLT]) begin
            disableVolt = 1'b1;
        end else if (!cmdBits[CB_QUICK_STOP]) begin
            quickStop = 1'b1;
        end else if (!cmdBits[CB_SWITCH_ON]) begin
            cmd = CMD_SHUTDOWN;
        end else if (!cmdBits[CB_ENABLE_OP]) begin
            cmd = CMD_SWITCH_ON;
        end else begin
            cmd = CMD_ENABLE_OP;
        end
    end
endmodule

/* File: rtl/dcs_drive_ctrl.sv */
`timescale 1ns/100ps
module dcs_drive_ctrl
    import dcs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Object access from the process data path.
    input wire logic wrEn,
    input wire logic [15:0] wrIndex,
    input wire logic [15:0] wrData,
    input wire logic [15:0] rdIndex,
    output logic [15:0] rdData,
    // Drive conditions, synchronous to clock.
    input wire dcs_mode_t opMode,
    input wire logic [1:0] haltOption,
    input wire logic mainPower,
    input wire logic initDone,
    input wire logic alarmEvent,
    input wire logic [15:0] alarmCode,
    input wire logic encoderAlarm,
    input wire logic warnEvent,
    input wire logic remoteCtrl,
    input wire logic limitActive,
    input wire logic motionDone,
    input wire logic atProfilePos,
    input wire logic motorStopped,
    input wire logic homingFound,
    input wire logic homingFail,
    // Motion commands.
    output logic driveEnable,
    output logic powerEnable,
    output logic quickStopRun,
    output logic haltRun,
    output logic [1:0] haltMode,
    output logic setpointLoad,
    output logic setpointRelative,
    output logic homingRun,
    output logic faultCleared,
    // Registered words.
    output logic [15:0] commandWord,
    output logic [15:0] stateWord,
    output logic [15:0] lastAlarm
);
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] cmdPrev;
        logic [15:0] alarm;
        logic [15:0] status;
        dcs_state_t state;
        logic [7:0] reactCnt;
        logic alarmActive;
        logic warning;
        logic spPending;
        logic spWaitProfile;
        logic spLoad;
        logic spRel;
        logic homeDone;
        logic homeErr;
        logic homeStarted;
        logic clrPulse;
    } dcs_regs_t;

    dcs_regs_t r_ff;
    dcs_regs_t nxt_r;
    logic disableVolt;
    logic quickStopCmd;
    dcs_cmd_t decCmd;
    logic bit4Rise;
    logic faultRise;
    logic halt;
    logic [2:0] homeCode;

    dcs_cmd_decode uDecode (
        .cmdBits(r_ff.cmd[3:0]),
        .disableVolt(disableVolt),
        .quickStop(quickStopCmd),
        .cmd(decCmd)
    );

    assign bit4Rise = r_ff.cmd[CB_NEW_SETPOINT]
        & ~r_ff.cmdPrev[CB_NEW_SETPOINT];
    assign faultRise = r_ff.cmd[CB_FAULT_RESET]
        & ~r_ff.cmdPrev[CB_FAULT_RESET];
    assign halt = r_ff.cmd[CB_HALT];

    function automatic logic [6:0] state_bits(input dcs_state_t s);
        // Returns status bits 6..0 with bit 4 left clear.
        case (s)
            ST_NOT_READY: state_bits = 7'b000_0000;
            ST_SW_ON_DIS: state_bits = 7'b100_0000;
            ST_READY: state_bits = 7'b010_0001;
            ST_SWITCHED_ON: state_bits = 7'b010_0011;
            ST_OP_ENABLED: state_bits = 7'b010_0111;
            ST_QSTOP: state_bits = 7'b000_0111;
            ST_FAULT_REACT: state_bits = 7'b000_1111;
            ST_FAULT: state_bits = 7'b000_1000;
            default: state_bits = 7'b000_0000;
        endcase
    endfunction

    always_comb begin
        nxt_r = r_ff;
        nxt_r.spLoad = 1'b0;
        nxt_r.clrPulse = 1'b0;
        nxt_r.cmdPrev = r_ff.cmd;
        if (wrEn && wrIndex == OFS_CMD_WORD) begin
            nxt_r.cmd = wrData;
        end
        if (alarmEvent) begin
            nxt_r.alarm = alarmCode;
            nxt_r.alarmActive = 1'b1;
        end else if (faultRise) begin
            nxt_r.alarmActive = 1'b0;
            nxt_r.clrPulse = 1'b1;
        end
        if (warnEvent) begin
            nxt_r.warning = 1'b1;
        end else if (faultRise) begin
            nxt_r.warning = 1'b0;
        end

        case (r_ff.state)
            ST_NOT_READY: begin
                if (initDone) begin
                    nxt_r.state = ST_SW_ON_DIS;
                end
            end
            ST_SW_ON_DIS: begin
                if (decCmd == CMD_SHUTDOWN) begin
                    nxt_r.state = ST_READY;
                end
            end
            ST_READY: begin
                if (disableVolt || quickStopCmd) begin
                    nxt_r.state = ST_SW_ON_DIS;
                end else if (decCmd == CMD_SWITCH_ON) begin
                    nxt_r.state = ST_SWITCHED_ON;
                end else if (decCmd == CMD_ENABLE_OP) begin
                    nxt_r.state = ST_OP_ENABLED;
                end
            end
            ST_SWITCHED_ON: begin
                if (disableVolt || quickStopCmd) begin
                    nxt_r.state = ST_SW_ON_DIS;
                end else if (decCmd == CMD_SHUTDOWN) begin
                    nxt_r.state = ST_READY;
                end else if (decCmd == CMD_ENABLE_OP) begin
                    nxt_r.state = ST_OP_ENABLED;
                end
            end
            ST_OP_ENABLED: begin
                if (disableVolt) begin
                    nxt_r.state = ST_SW_ON_DIS;
                end else if (quickStopCmd) begin
                    nxt_r.state = ST_QSTOP;
                end else if (decCmd == CMD_SHUTDOWN) begin
                    nxt_r.state = ST_READY;
                end else if (decCmd == CMD_SWITCH_ON) begin
                    nxt_r.state = ST_SWITCHED_ON;
                end
            end
            ST_QSTOP: begin
                if (disableVolt || motorStopped) begin
                    nxt_r.state = ST_SW_ON_DIS;
                end
            end
            ST_FAULT_REACT: begin
                if (r_ff.reactCnt == FAULT_REACT_CYCLES) begin
                    nxt_r.state = ST_FAULT;
                end else begin
                    nxt_r.reactCnt = r_ff.reactCnt + 8'h01;
                end
            end
            ST_FAULT: begin
                if (faultRise && !alarmEvent) begin
                    nxt_r.state = ST_SW_ON_DIS;
                end
            end
            default: nxt_r.state = ST_NOT_READY;
        endcase
        if (alarmEvent && r_ff.state != ST_FAULT
            && r_ff.state != ST_FAULT_REACT) begin
            nxt_r.state = ST_FAULT_REACT;
            nxt_r.reactCnt = 8'h00;
        end

        if (opMode == MODE_PROFILE_POSITION
            && r_ff.state == ST_OP_ENABLED) begin
            nxt_r.spRel = r_ff.cmd[CB_RELATIVE];
            if (bit4Rise && r_ff.cmd[CB_IMMEDIATE]) begin
                nxt_r.spLoad = 1'b1;
                nxt_r.spPending = 1'b0;
            end else if (bit4Rise) begin
                nxt_r.spPending = 1'b1;
                nxt_r.spWaitProfile = r_ff.cmd[CB_CHANGE_ON_SP];
            end else if (r_ff.spPending && !halt
                && (r_ff.spWaitProfile ? atProfilePos : motionDone)) begin
                nxt_r.spLoad = 1'b1;
                nxt_r.spPending = 1'b0;
            end
        end else begin
            nxt_r.spPending = 1'b0;
        end

        if (opMode == MODE_HOMING_MODE) begin
            if (bit4Rise) begin
                nxt_r.homeStarted = 1'b1;
                nxt_r.homeDone = 1'b0;
                nxt_r.homeErr = 1'b0;
            end else if (!r_ff.cmd[CB_NEW_SETPOINT]) begin
                nxt_r.homeStarted = 1'b0;
            end
            if (r_ff.homeStarted && homingFail) begin
                nxt_r.homeErr = 1'b1;
            end else if (r_ff.homeStarted && homingFound) begin
                nxt_r.homeDone = 1'b1;
            end
        end
        if (encoderAlarm) begin
            nxt_r.homeDone = 1'b0;
        end

        homeCode = 3'b000;
        if (opMode == MODE_HOMING_MODE) begin
            if (nxt_r.homeErr) begin
                homeCode = {1'b1, 1'b0, motorStopped};
            end else if (nxt_r.homeDone) begin
                homeCode = 3'b011;
            end else if (!nxt_r.homeStarted || halt) begin
                homeCode = 3'b001;
            end
        end else begin
            homeCode = {1'b0, 1'b0, motionDone};
        end

        nxt_r.status = 16'h0000;
        nxt_r.status[6:0] = state_bits(nxt_r.state);
        nxt_r.status[SB_VOLTAGE] = mainPower;
        nxt_r.status[SB_WARNING] = nxt_r.warning;
        nxt_r.status[SB_REMOTE] = remoteCtrl;
        nxt_r.status[SB_LIMIT] = limitActive;
        nxt_r.status[SB_HOME_ERR] = homeCode[2];
        nxt_r.status[SB_ATTAINED] = homeCode[1];
        nxt_r.status[SB_TARGET] = homeCode[0];
        nxt_r.status[SB_ABS_VALID] = nxt_r.homeDone && !encoderAlarm;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            r_ff <= '0;
            r_ff.cmd <= RST_CMD_WORD;
            r_ff.alarm <= RST_LAST_ALARM;
            r_ff.state <= ST_NOT_READY;
        end else begin
            r_ff <= nxt_r;
        end
    end

    always_comb begin
        case (rdIndex)
            OFS_LAST_ALARM: rdData = r_ff.alarm;
            OFS_CMD_WORD: rdData = r_ff.cmd;
            OFS_STATE_WORD: rdData = r_ff.status;
            default: rdData = 16'h0000;
        endcase
    end

    assign powerEnable = r_ff.state == ST_SWITCHED_ON
        || r_ff.state == ST_OP_ENABLED || r_ff.state == ST_QSTOP;
    assign driveEnable = r_ff.state == ST_OP_ENABLED;
    assign quickStopRun = r_ff.state == ST_QSTOP;
    assign haltRun = driveEnable && halt;
    assign haltMode = haltOption;
    assign setpointLoad = r_ff.spLoad;
    assign setpointRelative = r_ff.spRel;
    assign homingRun = driveEnable && opMode == MODE_HOMING_MODE
        && r_ff.homeStarted && !halt && !r_ff.homeDone && !r_ff.homeErr;
    assign faultCleared = r_ff.clrPulse;
    assign commandWord = r_ff.cmd;
    assign stateWord = r_ff.status;
    assign lastAlarm = r_ff.alarm;
endmodule

/* File: dv/dcs_drive_ctrl_monitor.sv */
`timescale 1ns/100ps
module dcs_drive_ctrl_monitor
    import dcs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Object access.
    input wire logic wrEn,
    input wire logic [15:0] wrIndex,
    input wire logic [15:0] wrData,
    input wire logic [15:0] rdIndex,
    input wire logic [15:0] rdData,
    // Drive conditions.
    input wire logic [1:0] haltOption,
    input wire logic mainPower,
    input wire logic alarmEvent,
    input wire logic [15:0] alarmCode,
    input wire logic warnEvent,
    // Commands and words.
    input wire logic driveEnable,
    input wire logic haltRun,
    input wire logic [1:0] haltMode,
    input wire logic setpointLoad,
    input wire logic [15:0] commandWord,
    input wire logic [15:0] stateWord,
    input wire logic [15:0] lastAlarm
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_cmd_write: assert property (
        wrEn && wrIndex == OFS_CMD_WORD |=> commandWord == $past(wrData))
        else $error("command word not taken");
    a_alarm_latch: assert property (
        alarmEvent |=> lastAlarm == $past(alarmCode))
        else $error("alarm code not latched");
    a_alarm_read: assert property (
        rdIndex == OFS_LAST_ALARM |-> rdData == lastAlarm)
        else $error("alarm read mismatch");
    a_reserved_bits: assert property (
        !stateWord[8] && !stateWord[15])
        else $error("reserved status bit set");
    a_disabled_code: assert property (
        stateWord[SB_SW_ON_DIS] |-> stateWord[3:0] == 4'h0)
        else $error("switch-on disabled with state bits");
    a_state_code: assert property (
        stateWord[3:0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h8})
        else $error("illegal state code");
    a_enable_state: assert property (
        driveEnable |-> stateWord[3:0] == 4'h7 && stateWord[SB_QUICK_STOP])
        else $error("enable without enabled state");
    a_power_bit: assert property (
        $past(rstn) |-> stateWord[SB_VOLTAGE] == $past(mainPower))
        else $error("power bit wrong");
    a_warn_bit: assert property (
        warnEvent |-> ##[1:2] stateWord[SB_WARNING])
        else $error("warning not shown");
    a_halt_run: assert property (
        haltRun |-> driveEnable && commandWord[CB_HALT] && haltMode == haltOption)
        else $error("halt without cause");

    c_enabled: cover property (driveEnable);
    c_setpoint: cover property (setpointLoad);
    c_halt: cover property (haltRun);
endmodule

bind dcs_drive_ctrl dcs_drive_ctrl_monitor dcs_drive_ctrl_monitor_inst (
    .clock(clock), .rstn(rstn), .wrEn(wrEn), .wrIndex(wrIndex),
    .wrData(wrData), .rdIndex(rdIndex), .rdData(rdData),
    .haltOption(haltOption), .mainPower(mainPower),
    .alarmEvent(alarmEvent), .alarmCode(alarmCode), .warnEvent(warnEvent),
    .driveEnable(driveEnable), .haltRun(haltRun), .haltMode(haltMode),
    .setpointLoad(setpointLoad), .commandWord(commandWord),
    .stateWord(stateWord), .lastAlarm(lastAlarm)
);

/* File: dv/dcs_master_model.sv */
`timescale 1ns/100ps
module dcs_master_model
    import dcs_pkg::*;
(
    // Clock and mode.
    input wire logic clock,
    input wire dcs_mode_t opMode,
    // Object writes.
    output logic wrEn,
    output logic [15:0] wrIndex,
    output logic [15:0] wrData
);
    initial begin
        wrEn = 1'b0;
        wrIndex = 16'h0000;
        wrData = 16'h0000;
    end

    // One write held over one rising edge; released lines show junk.
    task automatic put(input logic [15:0] idx, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (opMode inside {MODE_PROFILE_VELOCITY, MODE_PROFILE_TORQUE}) begin
            v = v & 16'hFD8F;
        end
        @(negedge clock);
        wrEn = 1'b1;
        wrIndex = idx;
        wrData = v;
        @(negedge clock);
        wrEn = 1'b0;
        wrIndex = ~idx;
        wrData = ~v;
    endtask
endmodule

/* File: dv/dcs_drive_ctrl_tb_top.sv */
`timescale 1ns/100ps
module dcs_drive_ctrl_tb_top
    import dcs_pkg::*;
;
    logic clock, rstn, wrEn, mainPower, initDone, alarmEvent, encoderAlarm;
    logic warnEvent, remoteCtrl, limitActive, motionDone, atProfilePos;
    logic motorStopped, homingFound, homingFail, driveEnable, quickStopRun;
    logic haltRun, setpointLoad, setpointRelative, homingRun, faultCleared;
    logic powerEnable;
    logic [15:0] wrIndex, wrData, rdIndex, rdData, alarmCode, commandWord;
    logic [15:0] stateWord, lastAlarm;
    logic [1:0] haltOption, haltMode;
    dcs_mode_t opMode;
    int fails = 0;
    int cmpCount = 0;
    int loads = 0;
    int clears = 0;
    logic [15:0] upCmd [3] = '{16'h0006, 16'h0007, 16'h000F};
    logic [15:0] upSt [3] = '{16'h0031, 16'h0033, 16'h0037};

    dcs_master_model dcs_master_model_inst (.clock(clock), .opMode(opMode),
        .wrEn(wrEn), .wrIndex(wrIndex), .wrData(wrData));

    dcs_drive_ctrl dcs_drive_ctrl_inst (.clock(clock), .rstn(rstn),
        .wrEn(wrEn), .wrIndex(wrIndex), .wrData(wrData), .rdIndex(rdIndex),
        .rdData(rdData), .opMode(opMode), .haltOption(haltOption),
        .mainPower(mainPower), .initDone(initDone), .alarmEvent(alarmEvent),
        .alarmCode(alarmCode), .encoderAlarm(encoderAlarm),
        .warnEvent(warnEvent), .remoteCtrl(remoteCtrl),
        .limitActive(limitActive), .motionDone(motionDone),
        .atProfilePos(atProfilePos), .motorStopped(motorStopped),
        .homingFound(homingFound), .homingFail(homingFail),
        .driveEnable(driveEnable), .powerEnable(powerEnable),
        .quickStopRun(quickStopRun),
        .haltRun(haltRun), .haltMode(haltMode), .setpointLoad(setpointLoad),
        .setpointRelative(setpointRelative), .homingRun(homingRun),
        .faultCleared(faultCleared), .commandWord(commandWord),
        .stateWord(stateWord), .lastAlarm(lastAlarm));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        if (setpointLoad === 1'b1) loads++;
        if (faultCleared === 1'b1) clears++;
    end

    task automatic testDone;
        $display("compares %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] d);
        dcs_master_model_inst.put(OFS_CMD_WORD, d);
        repeat (3) @(negedge clock);
    endtask

    task automatic rc(input string nm, input logic [15:0] idx,
                      input logic [15:0] m, input logic [15:0] e);
        @(negedge clock);
        rdIndex = idx;
        #1;
        chk(nm, rdData & m, e);
    endtask

    task automatic waitSt(input logic [15:0] m, input logic [15:0] e);
        int n;
        n = 0;
        while ((stateWord & m) !== e && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk("state wait", stateWord & m, e);
        if ((stateWord & m) !== e) testDone();
    endtask

    task automatic goUp;
        for (int i = 0; i < 3; i++) begin
            wr(upCmd[i]);
            rc("state", OFS_STATE_WORD, 16'h007F, upSt[i]);
        end
    endtask

    initial begin
        {rstn, initDone, alarmEvent, encoderAlarm, warnEvent} = 5'h00;
        {limitActive, motionDone, atProfilePos, motorStopped} = 4'h0;
        {homingFound, homingFail} = 2'h0;
        mainPower = 1'b1;
        remoteCtrl = 1'b1;
        haltOption = 2'h2;
        alarmCode = 16'h0000;
        rdIndex = 16'h0000;
        opMode = MODE_PROFILE_POSITION;
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        rc("command", OFS_CMD_WORD, 16'hFFFF, 16'h0000);
        rc("alarm", OFS_LAST_ALARM, 16'hFFFF, 16'h0000);
        rc("unmapped", 16'h1234, 16'hFFFF, 16'h0000);
        rc("not ready", OFS_STATE_WORD, 16'h004F, 16'h0000);
        initDone = 1'b1;
        waitSt(16'h005F, 16'h0050);
        rc("remote", OFS_STATE_WORD, 16'h8300, 16'h0200);
        goUp();
        wr(16'h000B);
        rc("qstop", OFS_STATE_WORD, 16'h007F, 16'h0017);
        chk("qstop run", {15'h0000, quickStopRun}, 16'h0001);
        chk("qstop power", {15'h0000, powerEnable}, 16'h0001);
        motorStopped = 1'b1;
        waitSt(16'h005F, 16'h0050);
        motorStopped = 1'b0;
        goUp();
        wr(16'h000D);
        chk("enable", {15'h0000, driveEnable}, 16'h0000);
        rc("off", OFS_STATE_WORD, 16'h004F, 16'h0040);
        chk("off power", {15'h0000, powerEnable}, 16'h0000);
        goUp();
        wr(16'h001F);
        chk("queued", loads[15:0], 16'h0000);
        motionDone = 1'b1;
        repeat (3) @(negedge clock);
        motionDone = 1'b0;
        chk("queued", loads[15:0], 16'h0001);
        wr(16'h002F);
        wr(16'h007F);
        chk("immediate", loads[15:0], 16'h0002);
        chk("relative", {15'h0000, setpointRelative}, 16'h0001);
        wr(16'h020F);
        wr(16'h021F);
        chk("profile", loads[15:0], 16'h0002);
        atProfilePos = 1'b1;
        repeat (3) @(negedge clock);
        atProfilePos = 1'b0;
        chk("profile", loads[15:0], 16'h0003);
        wr(16'h000F);
        wr(16'h003F);
        chk("absolute", {15'h0000, setpointRelative}, 16'h0000);
        opMode = MODE_PROFILE_VELOCITY;
        wr(16'h017F);
        rc("masked", OFS_CMD_WORD, 16'hFFFF, 16'h010F);
        chk("halt", {14'h0000, haltRun, haltMode}, 16'h0006);
        wr(16'h000F);
        chk("go on", {15'h0000, haltRun}, 16'h0000);
        opMode = MODE_PROFILE_TORQUE;
        wr(16'h027F);
        rc("torque", OFS_CMD_WORD, 16'hFFFF, 16'h000F);
        opMode = MODE_HOMING_MODE;
        rc("idle", OFS_STATE_WORD, 16'h3400, 16'h0400);
        wr(16'h001F);
        chk("homing", {15'h0000, homingRun}, 16'h0001);
        rc("busy", OFS_STATE_WORD, 16'h3400, 16'h0000);
        wr(16'h011F);
        chk("homing halt", {15'h0000, homingRun}, 16'h0000);
        wr(16'h001F);
        homingFound = 1'b1;
        @(negedge clock);
        homingFound = 1'b0;
        waitSt(16'h7400, 16'h5400);
        encoderAlarm = 1'b1;
        @(negedge clock);
        encoderAlarm = 1'b0;
        rc("abs lost", OFS_STATE_WORD, 16'h4000, 16'h0000);
        homingFail = 1'b1;
        @(negedge clock);
        homingFail = 1'b0;
        rc("home error", OFS_STATE_WORD, 16'h3400, 16'h2000);
        warnEvent = 1'b1;
        @(negedge clock);
        warnEvent = 1'b0;
        rc("warning", OFS_STATE_WORD, 16'h0080, 16'h0080);
        alarmCode = 16'hA5C3;
        alarmEvent = 1'b1;
        @(negedge clock);
        alarmEvent = 1'b0;
        waitSt(16'h004F, 16'h000F);
        waitSt(16'h004F, 16'h0008);
        dcs_master_model_inst.put(OFS_LAST_ALARM, 16'h1111);
        rc("alarm", OFS_LAST_ALARM, 16'hFFFF, 16'hA5C3);
        wr(16'h0000);
        wr(16'h0080);
        chk("reset", clears[15:0], 16'h0001);
        waitSt(16'h00CF, 16'h0040);
        testDone();
    end
endmodule
